// >>> common/power_down_defs.vh
// Constants for the converter power-down controller
`ifndef POWER_DOWN_DEFS_VH
`define POWER_DOWN_DEFS_VH
`define CLK_PERIOD_PS       25000
`define CONV_WAKE_TIME_NS   2000
`define PLL_SETTLE_TIME_NS  20000
`define CONV_WAKE_CYCLES    ((`CONV_WAKE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define PLL_SETTLE_CYCLES   ((`PLL_SETTLE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define CODE_WIDTH          8
`define CODE_RESET          8'h00
`define CNT_WIDTH           16
`endif

// >>> hw/adc_power_down_control.v
// Power-down sequencing for converter, PLL and capture buffer
// How it works
// RQ1: A high full shutdown request powers down converter, PLL and buffer.
// RQ2: The controller may stop the input clock after raising shutdown.
// RQ3: Converter is ready about 2 us after the full shutdown request falls.
// RQ4: PLL clock is flagged stable only 20 us after full shutdown falls.
// RQ5: Output code holds the last conversion while shut down or unclocked.
// RQ6: Raising full shutdown invalidates all captured buffer contents.
// RQ7: Converter sleep powers down only the converter; buffer stays live.
// RQ8: Converter is ready about 2 us after the sleep request falls.
// RQ9: The PLL keeps running during converter sleep.
// RQ10: The controller should keep the clock running during sleep.
// RQ11: Full shutdown takes precedence over converter sleep.
// RQ12: Recovery counters start on request release; results stay invalid.
`timescale 1ns/1ps
`include "power_down_defs.vh"

module adc_power_down_control #(
  parameter CNT_W        = `CNT_WIDTH,
  parameter CODE_W       = `CODE_WIDTH,
  parameter CONV_CYCLES  = `CONV_WAKE_CYCLES,
  parameter PLL_CYCLES   = `PLL_SETTLE_CYCLES
) (
  input  wire              clk_sys_in,
  input  wire              arst_n_in,
  input  wire              full_shutdown_request_in,
  input  wire              converter_sleep_request_in,
  input  wire [CODE_W-1:0] conv_code_in,
  input  wire              conv_code_valid_in,
  output reg               conv_power_en_out,
  output reg               pll_power_en_out,
  output reg               buffer_power_en_out,
  output reg               buffer_invalidate_out,
  output reg               conv_ready_out,
  output reg               pll_stable_out,
  output reg  [CODE_W-1:0] code_out,
  output reg               code_valid_out
);

  // --------------------------------------------------------------
  // Request synchronisers
  // --------------------------------------------------------------
  reg  shut_meta;
  reg  shut_sync;
  reg  sleep_meta;
  reg  sleep_sync;
  reg  shut_prev;

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shut_meta  <= 1'b0;
      shut_sync  <= 1'b0;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      shut_prev  <= 1'b0;
    end else begin
      shut_meta  <= full_shutdown_request_in;
      shut_sync  <= shut_meta;
      sleep_meta <= converter_sleep_request_in;
      sleep_sync <= sleep_meta;
      shut_prev  <= shut_sync;
    end
  end

  // Shutdown dominates sleep for every consumer of the two requests
  wire conv_off  = shut_sync | sleep_sync;          // RQ11
  wire shut_rise = shut_sync & ~shut_prev;          // RQ6

  // --------------------------------------------------------------
  // Counter helpers
  // --------------------------------------------------------------
  // Both recovery timers share one saturating step, so the
  // clear, count and hold priority is written only once
  function cnt_reached;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] limit;
    begin
      cnt_reached = (cnt >= limit);
    end
  endfunction

  function [CNT_W-1:0] cnt_step;
    input [CNT_W-1:0] cnt;
    input             clear;
    input             done;
    begin
      if (clear)
        cnt_step = {CNT_W{1'b0}};
      else if (!done)
        cnt_step = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      else
        cnt_step = cnt;
    end
  endfunction

  // --------------------------------------------------------------
  // Recovery counters
  // --------------------------------------------------------------
  // Counters are held at zero while powered down, so they only start
  // on release; a stopped clock during shutdown is therefore harmless.
  // Limits are cut to the counter width on purpose: CNT_W must be
  // chosen wide enough to hold PLL_CYCLES.
  localparam [CNT_W-1:0] CONV_LIMIT = CONV_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] PLL_LIMIT  = PLL_CYCLES[CNT_W-1:0];

  reg  [CNT_W-1:0] conv_cnt;
  reg  [CNT_W-1:0] pll_cnt;
  reg  [CNT_W-1:0] next_conv_cnt;
  reg  [CNT_W-1:0] next_pll_cnt;
  wire             conv_done;
  wire             pll_done;

  assign conv_done = cnt_reached(conv_cnt, CONV_LIMIT);
  assign pll_done  = cnt_reached(pll_cnt, PLL_LIMIT);

  always @* begin
    // Converter count restarts only when both requests are released
    next_conv_cnt = cnt_step(conv_cnt, conv_off, conv_done); // RQ3 RQ8
    // Sleep alone leaves the PLL count untouched
    next_pll_cnt  = cnt_step(pll_cnt, shut_sync, pll_done);  // RQ4 RQ9
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_cnt <= {CNT_W{1'b0}};
      pll_cnt  <= {CNT_W{1'b0}};
    end else begin
      conv_cnt <= next_conv_cnt;                    // RQ12
      pll_cnt  <= next_pll_cnt;                     // RQ12
    end
  end

  // --------------------------------------------------------------
  // Power mode
  // --------------------------------------------------------------
  localparam [1:0] MODE_RUN   = 2'h0;
  localparam [1:0] MODE_WAKE  = 2'h1;
  localparam [1:0] MODE_SLEEP = 2'h2;
  localparam [1:0] MODE_SHUT  = 2'h3;

  reg  [1:0] mode;
  reg  [1:0] next_mode;

  // Requests are levels, so any mode may be left for any other one;
  // outputs follow next_mode so that they keep the sync latency.
  always @* begin
    next_mode = mode;
    case (mode)
      MODE_RUN, MODE_WAKE: begin
        if (shut_sync)
          next_mode = MODE_SHUT;                    // RQ1 RQ11
        else if (sleep_sync)
          next_mode = MODE_SLEEP;                   // RQ7
        else if (conv_done)
          next_mode = MODE_RUN;
        else
          next_mode = MODE_WAKE;                    // RQ12
      end
      MODE_SLEEP: begin
        if (shut_sync)
          next_mode = MODE_SHUT;                    // RQ11
        else if (!sleep_sync)
          next_mode = conv_done ? MODE_RUN : MODE_WAKE; // RQ8
      end
      MODE_SHUT: begin
        if (!shut_sync && sleep_sync)
          next_mode = MODE_SLEEP;
        else if (!shut_sync)
          next_mode = conv_done ? MODE_RUN : MODE_WAKE; // RQ3
      end
      default: begin
        next_mode = MODE_SHUT;
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in)
      mode <= MODE_WAKE;
    else
      mode <= next_mode;
  end

  wire mode_conv_on = (next_mode == MODE_RUN) | (next_mode == MODE_WAKE);
  wire mode_pll_on  = (next_mode != MODE_SHUT);
  wire mode_ready   = (next_mode == MODE_RUN);
  wire take_code    = mode_ready & conv_code_valid_in;

  // --------------------------------------------------------------
  // Power gating
  // --------------------------------------------------------------
  // Buffer shares the PLL gate: only a full shutdown removes it
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_power_en_out     <= 1'b0;
      pll_power_en_out      <= 1'b0;
      buffer_power_en_out   <= 1'b0;
      buffer_invalidate_out <= 1'b0;
    end else begin
      conv_power_en_out     <= mode_conv_on;        // RQ1 RQ7 RQ11
      pll_power_en_out      <= mode_pll_on;         // RQ1 RQ9
      buffer_power_en_out   <= mode_pll_on;         // RQ1 RQ7
      buffer_invalidate_out <= shut_rise;           // RQ6
    end
  end

  // --------------------------------------------------------------
  // Recovery status
  // --------------------------------------------------------------
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_ready_out <= 1'b0;
      pll_stable_out <= 1'b0;
    end else begin
      conv_ready_out <= mode_ready;                 // RQ12
      pll_stable_out <= mode_pll_on & pll_done;     // RQ4
    end
  end

  // --------------------------------------------------------------
  // Held output code
  // --------------------------------------------------------------
  // Hold the last code whenever conversion is off or not ready, so a
  // reader never sees a code taken before the converter settled.
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_out       <= `CODE_RESET;
      code_valid_out <= 1'b0;
    end else begin
      code_valid_out <= take_code;                  // RQ12
      if (take_code)
        code_out <= conv_code_in;                   // RQ5
    end
  end

endmodule // adc_power_down_control

// >>> bench/pd_request_driver.sv
// Controller model that drives the two power-down request levels
`timescale 1ns/1ps
module pd_request_driver (input wire clk_sys_in, output reg
  full_shutdown_request_out = 1'b0, converter_sleep_request_out = 1'b0);
  // Clock is never stopped here, so PLL lock survives sleep
  task drive(input [1:0] req, input int n);
    {full_shutdown_request_out, converter_sleep_request_out} = req;
    repeat (n) @(posedge clk_sys_in) #1;
  endtask
endmodule // pd_request_driver

// >>> bench/adc_power_down_control_checker.sv
// Port assertions for the power-down controller
`timescale 1ns/1ps
module adc_power_down_control_checker #(
  parameter int CONV_CYCLES = 4,
  parameter int PLL_CYCLES  = 16
) (
  input wire clk_sys_in, arst_n_in, full_shutdown_request_in,
  converter_sleep_request_in, conv_ready_out, conv_power_en_out,
  pll_power_en_out, buffer_invalidate_out, pll_stable_out);
  localparam int CW = CONV_CYCLES + 5;
  wire d = full_shutdown_request_in, s = converter_sleep_request_in;
  wire r = conv_ready_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_up; !r[*4] ##[1:CW] r; endsequence
  property p_off; d[*4] |-> !conv_power_en_out && !pll_power_en_out;
  endproperty
  a_off: assert property (p_off) else $error("on in shutdown");
  property p_inv; $rose(d) |-> ##[2:3] buffer_invalidate_out; endproperty
  a_inv: assert property (p_inv) else $error("no invalidate");
  property p_up; $fell(d || s) && !d && !s |-> s_up; endproperty
  a_up: assert property (p_up) else $error("bad wake");
  // Edges since the shutdown request was last seen high
  logic [15:0] since_rel;
  always @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in) since_rel <= 16'h0000;
    else if (d) since_rel <= 16'h0000;
    else if (since_rel != 16'hFFFF) since_rel <= since_rel + 16'h0001;
  sequence s_sleep_only; (s && !d)[*4]; endsequence
  property p_sleep; s_sleep_only |-> !conv_power_en_out && pll_power_en_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep");
  property p_pulse; buffer_invalidate_out |=> !buffer_invalidate_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long invalidate");
  property p_rdy; !conv_power_en_out |-> !conv_ready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready while off");
  property p_pll; $rose(pll_stable_out) |-> since_rel >= PLL_CYCLES;
  endproperty
  a_pll: assert property (p_pll) else $error("early pll");
endmodule // adc_power_down_control_checker

// >>> bench/adc_power_down_control_tb.sv
// Self-checking bench for the power-down controller
`timescale 1ns/1ps
module adc_power_down_control_tb;
  reg clk_sys_in = 1'b0, arst_n_in = 1'b0, conv_code_valid_in = 1'b1;
  reg [7:0] conv_code_in = 8'h5A;
  wire full_shutdown_request_in, converter_sleep_request_in, conv_ready_out;
  wire conv_power_en_out, pll_power_en_out, buffer_power_en_out;
  wire buffer_invalidate_out, pll_stable_out, code_valid_out;
  wire [7:0] code_out;
  wire [2:0] pw = {conv_power_en_out, pll_power_en_out, buffer_power_en_out};
  int n_fail = 0, tests_run = 0;
  reg clk_run = 1'b1;
  // Gating the clock stands in for the controller halting it
  always #12.5 if (clk_run) clk_sys_in = ~clk_sys_in;
  pd_request_driver ctl (.clk_sys_in, .full_shutdown_request_out(
    full_shutdown_request_in), .converter_sleep_request_out(
    converter_sleep_request_in));
  adc_power_down_control #(.CONV_CYCLES(4), .PLL_CYCLES(16)) dut (
    .clk_sys_in                 (clk_sys_in),
    .arst_n_in                  (arst_n_in),
    .full_shutdown_request_in   (full_shutdown_request_in),
    .converter_sleep_request_in (converter_sleep_request_in),
    .conv_code_in               (conv_code_in),
    .conv_code_valid_in         (conv_code_valid_in),
    .conv_power_en_out          (conv_power_en_out),
    .pll_power_en_out           (pll_power_en_out),
    .buffer_power_en_out        (buffer_power_en_out),
    .buffer_invalidate_out      (buffer_invalidate_out),
    .conv_ready_out             (conv_ready_out),
    .pll_stable_out             (pll_stable_out),
    .code_out                   (code_out),
    .code_valid_out             (code_valid_out));
  task chk(input logic [11:0] got, exp);
    tests_run++;
    if (got !== exp) n_fail++;
    if (got !== exp) $display("CHECK FAILED at %0t: %h", $time, got);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_shut;
    ctl.drive(2'h2, 3);
    chk(buffer_invalidate_out, 12'h001);
    ctl.drive(2'h2, 1);
    chk(buffer_invalidate_out, 12'h000);
    ctl.drive(2'h2, 2);
    conv_code_in = 8'hC3;
    ctl.drive(2'h2, 2);
    chk({code_valid_out, pw, code_out}, 12'h05A);
    clk_run = 1'b0;
    #500 chk(code_out, 12'h05A);
    clk_run = 1'b1;
    ctl.drive(2'h0, 12);
    chk({conv_ready_out, pll_stable_out, code_out}, 12'h2C3);
  endtask
  task t_sleep;
    ctl.drive(2'h3, 6);
    chk(pw, 12'h000);
    ctl.drive(2'h1, 24);
    chk({pw, pll_stable_out}, 12'h007);
    ctl.drive(2'h0, 12);
    chk({conv_ready_out, pw}, 12'h00F);
  endtask
  task t_valid;
    conv_code_valid_in = 1'b0;
    conv_code_in = 8'h96;
    ctl.drive(2'h0, 3);
    chk({code_valid_out, code_out}, 12'h0C3);
    conv_code_valid_in = 1'b1;
    ctl.drive(2'h0, 3);
    chk({code_valid_out, code_out}, 12'h196);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in) #1;
    arst_n_in = 1'b1;
    ctl.drive(2'h0, 30);
    t_shut;
    t_sleep;
    t_valid;
    print_verdict;
  end
  initial #50000 begin n_fail++; print_verdict; end
endmodule // adc_power_down_control_tb
bind adc_power_down_control adc_power_down_control_checker #(
  .CONV_CYCLES(CONV_CYCLES), .PLL_CYCLES(PLL_CYCLES)) chk_i (
  .clk_sys_in                 (clk_sys_in),
  .arst_n_in                  (arst_n_in),
  .full_shutdown_request_in   (full_shutdown_request_in),
  .converter_sleep_request_in (converter_sleep_request_in),
  .conv_ready_out             (conv_ready_out),
  .conv_power_en_out          (conv_power_en_out),
  .pll_power_en_out           (pll_power_en_out),
  .buffer_invalidate_out      (buffer_invalidate_out),
  .pll_stable_out             (pll_stable_out));
